// ===== rxbs_params.svh
// Named constants for the receive bit synchroniser: offsets, fields, divider codes, counts
`ifndef RXBS_PARAMS_SVH
`define RXBS_PARAMS_SVH

// Register bus geometry
`define RXBS_AW 8
`define RXBS_DW 32

// Register byte offsets
`define RXBS_OFS_CFG_A 8'h00
`define RXBS_OFS_CFG_C 8'h04
`define RXBS_OFS_CFG_E 8'h08
`define RXBS_OFS_RATE 8'h0C
`define RXBS_OFS_STAT 8'h10
`define RXBS_OFS_MASK 8'h14
`define RXBS_OFS_STATE 8'h18

// Word A, C and E field positions
`define RXBS_A_POL_BIT 4
`define RXBS_C_CLR_BIT 5
`define RXBS_E_MODE_HI 15
`define RXBS_E_MODE_LO 14
`define RXBS_E_TXCAP_BIT 13
`define RXBS_E_PAIR_BIT 12
`define RXBS_E_TLEN_HI 11
`define RXBS_E_TLEN_LO 7

// Rate register field positions
`define RXBS_RATE_D1_HI 1
`define RXBS_RATE_D1_LO 0
`define RXBS_RATE_D2_HI 4
`define RXBS_RATE_D2_LO 2
`define RXBS_RATE_D3_BIT 5

// First divider values per code, third divider values
`define RXBS_D1_VAL0 4'h1
`define RXBS_D1_VAL1 4'h5
`define RXBS_D1_VAL2 4'h6
`define RXBS_D1_VAL3 4'h8
`define RXBS_D3_SHORT 5'h0F
`define RXBS_D3_LONG 5'h10

// Deglitch vote
`define RXBS_DG_TAPS 7
`define RXBS_DG_HIGH 3'h5
`define RXBS_DG_LOW 3'h2

// Training length offset and silence limit in bit periods
`define RXBS_TB_EXTRA 7'h02
`define RXBS_TCNT_MAX 7'h7F
`define RXBS_SILENCE_BITS 6'h20

// Status bits
`define RXBS_EV_W 3
`define RXBS_EV_TRAIN 0
`define RXBS_EV_LOCK 1
`define RXBS_EV_LOSS 2

`endif

// ===== rxbs_pkg.sv
// Types shared by the receive bit synchroniser modules
`include "rxbs_params.svh"
package rxbs_pkg;

   typedef enum logic [1:0] {
      RXBS_M_RAW = 2'h0,
      RXBS_M_DGL = 2'h1,
      RXBS_M_REC = 2'h2,
      RXBS_M_TRN = 2'h3
   } rxbs_mode_t;

   typedef enum logic [1:0] {
      RXBS_SY_HUNT = 2'b01,
      RXBS_SY_LOCK = 2'b10
   } rxbs_sync_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [`RXBS_AW-1:0] addr;
      logic [`RXBS_DW-1:0] wdata;
   } rxbs_bus_t;

   typedef struct packed {
      logic rx_data;
      logic recovered_bit_clock;
      logic training_end_flag;
      logic tx_data_out;
   } rxbs_pins_t;

   typedef struct packed {
      logic polarity_invert;
      logic tx_capture;
      logic paired_pattern;
      logic [4:0] training_length_count;
      rxbs_mode_t receive_mode_select;
      logic [1:0] rate_divider_first;
      logic [2:0] rate_divider_second;
      logic rate_divider_third;
   } rxbs_cfg_t;

   typedef struct packed {
      logic [`RXBS_DG_TAPS-1:0] hist;
      logic out;
   } rxbs_dg_st_t;

   typedef struct packed {
      rxbs_cfg_t cfg;
      logic [`RXBS_EV_W-1:0] stat;
      logic [`RXBS_EV_W-1:0] mask;
      logic irq;
      logic [`RXBS_DW-1:0] rdata;
      logic [1:0] slc_sync;
      logic [1:0] txd_sync;
      logic [9:0] pre_cnt;
      logic [4:0] phase;
      logic dg_prev;
      rxbs_sync_t sync;
      logic [5:0] quiet;
      logic [6:0] tcnt;
      logic [1:0] hist;
      logic done;
      logic flag;
      logic bclk;
      logic rxd;
      logic txd;
      logic clr_pend;
   } rxbs_st_t;

endpackage : rxbs_pkg

// ===== rxbs_deglitch.sv
// Seven-sample majority deglitch filter with hold band
`timescale 1ns/1ps
`include "rxbs_params.svh"
module rxbs_deglitch
   import rxbs_pkg::*;
(
   input wire logic core_clk, // Master clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic tick, // Oversampling strobe
   input wire logic din, // Synchronised slicer level
   output logic dout // Filtered level, from a flop
);

   rxbs_dg_st_t q;
   rxbs_dg_st_t n;

   // Number of high samples in a window
   function automatic logic [2:0] rxbs_ones(input logic [`RXBS_DG_TAPS-1:0] v);
      logic [2:0] c;
      c = '0;
      for (int i = 0; i < `RXBS_DG_TAPS; i++) begin
         c = c + {2'b00, v[i]};
      end
      return c;
   endfunction : rxbs_ones

   logic [`RXBS_DG_TAPS-1:0] win;
   logic [2:0] ones;
   assign win = {q.hist[`RXBS_DG_TAPS-2:0], din};
   assign ones = rxbs_ones(win);

   // Vote only on sample strobes; between thresholds the old level holds
   always_comb begin
      n = q;
      if (tick) begin
         n.hist = win;
         if (ones >= `RXBS_DG_HIGH) begin
            n.out = 1'b1;
         end else if (ones <= `RXBS_DG_LOW) begin
            n.out = 1'b0;
         end
      end
   end

   // History and output start cleared
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign dout = q.out;

   high_vote_a: assert property (
      @(posedge core_clk) disable iff (rst) (tick && ones >= `RXBS_DG_HIGH) |=> dout)
      else $error("deglitch did not go high on five of seven");
   low_vote_a: assert property (
      @(posedge core_clk) disable iff (rst) (tick && ones <= `RXBS_DG_LOW) |=> !dout)
      else $error("deglitch did not go low on two of seven");
   hold_band_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (!tick || (ones > `RXBS_DG_LOW && ones < `RXBS_DG_HIGH)) |=> $stable(dout))
      else $error("deglitch output moved inside hold band");

endmodule : rxbs_deglitch

// ===== rxbs_top.sv
// Receive data recovery: raw, deglitch, clock recovery and training end detection
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "rxbs_params.svh"
// Functional notes
// - Bit clock is crystal over all three dividers
// - Dividers: 1/5/6/8, powers of two, 15/16
// - Two-bit mode field selects four modes
// - Raw: slicer passes, clock and flag low
// - Deglitch samples at crystal over first two
// - Five of seven high, two low, else hold
// - Deglitch: filter clock out, flag held low
// - Recovery aligns bit clock to data edges
// - Data changes on bit clock falling edge
// - Bit clock low until first data edge
// - Rising edge sits at bit centre
// - Pattern bit picks single or paired alternation
// - Self train pulses flag one bit period
// - Minimum training is four length plus pattern plus two
// - Sync logic self clears or clears on demand
// - Transmit capture aligns data to falling edge
// - Polarity bit inverts received data
module rxbs_top
   import rxbs_pkg::*;
(
   input wire logic core_clk, // Crystal master clock, 200 MHz
   input wire logic rst, // Asynchronous reset, active high
   input wire rxbs_bus_t bus, // Register request
   output logic [`RXBS_DW-1:0] rdata, // Read data, cycle after read strobe
   input wire logic slicer_in, // Data slicer comparator pin
   input wire logic transmit_data_in, // Transmit data pin from host
   output rxbs_pins_t pins, // Received data, bit clock, flag, transmit data
   output logic irq // Level interrupt
);

   rxbs_st_t q;
   rxbs_st_t n;

   logic dg;
   logic tick;
   logic edge_seen;
   logic recov;
   logic [3:0] d1v;
   logic [10:0] prod;
   logic [10:0] pm_w;
   logic [9:0] pre_max;
   logic [9:0] half_pre;
   logic [4:0] d3v;
   logic [4:0] d3m1;
   logic [4:0] half_ph;
   logic [6:0] tbmin;

   // First divider decode
   always_comb begin
      unique case (q.cfg.rate_divider_first)
         2'h0: d1v = `RXBS_D1_VAL0;
         2'h1: d1v = `RXBS_D1_VAL1;
         2'h2: d1v = `RXBS_D1_VAL2;
         2'h3: d1v = `RXBS_D1_VAL3;
      endcase
   end

   // Sample prescaler spans the first two dividers; the third counts samples per bit
   assign prod = {7'h00, d1v} << q.cfg.rate_divider_second;
   assign pm_w = prod - 11'h001;
   assign pre_max = pm_w[9:0];
   assign half_pre = prod[10:1];
   assign d3v = q.cfg.rate_divider_third ? `RXBS_D3_LONG : `RXBS_D3_SHORT;
   assign d3m1 = d3v - 5'h01;
   assign half_ph = {1'b0, d3v[4:1]};
   // Compare with >= so a rate change that shrinks the span cannot strand the count
   assign tick = (q.pre_cnt >= pre_max);
   assign edge_seen = (dg != q.dg_prev);
   assign recov = (q.cfg.receive_mode_select == RXBS_M_REC) || (q.cfg.receive_mode_select == RXBS_M_TRN);
   assign tbmin = {q.cfg.training_length_count, 2'b00} + {6'h00, q.cfg.paired_pattern} + `RXBS_TB_EXTRA;

   // Filter runs in every mode so switching modes does not start from stale history
   rxbs_deglitch u_dg (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick),
      .din(q.slc_sync[1]),
      .dout(dg)
   );

   logic [`RXBS_EV_W-1:0] ev;
   logic [`RXBS_EV_W-1:0] wclr;
   logic [`RXBS_DW-1:0] rd_v;
   logic bnd;
   logic cent;
   logic match;
   logic fall;

   // Next-state logic for the whole block
   always_comb begin
      n = q;
      ev = '0;
      wclr = '0;
      rd_v = '0;
      bnd = 1'b0;
      cent = 1'b0;
      match = 1'b0;
      fall = 1'b0;
      // Pins cross into the clock domain through two flops
      n.slc_sync = {q.slc_sync[0], slicer_in};
      n.txd_sync = {q.txd_sync[0], transmit_data_in};
      n.clr_pend = 1'b0;
      n.dg_prev = dg;
      n.rdata = '0;

      // Register writes
      if (bus.wr) begin
         case (bus.addr)
            `RXBS_OFS_CFG_A: n.cfg.polarity_invert = bus.wdata[`RXBS_A_POL_BIT];
            `RXBS_OFS_CFG_C: n.clr_pend = bus.wdata[`RXBS_C_CLR_BIT];
            `RXBS_OFS_CFG_E: begin
               n.cfg.receive_mode_select = rxbs_mode_t'(bus.wdata[`RXBS_E_MODE_HI:`RXBS_E_MODE_LO]);
               n.cfg.tx_capture = bus.wdata[`RXBS_E_TXCAP_BIT];
               n.cfg.paired_pattern = bus.wdata[`RXBS_E_PAIR_BIT];
               n.cfg.training_length_count = bus.wdata[`RXBS_E_TLEN_HI:`RXBS_E_TLEN_LO];
            end
            `RXBS_OFS_RATE: begin
               n.cfg.rate_divider_first = bus.wdata[`RXBS_RATE_D1_HI:`RXBS_RATE_D1_LO];
               n.cfg.rate_divider_second = bus.wdata[`RXBS_RATE_D2_HI:`RXBS_RATE_D2_LO];
               n.cfg.rate_divider_third = bus.wdata[`RXBS_RATE_D3_BIT];
            end
            `RXBS_OFS_STAT: wclr = bus.wdata[`RXBS_EV_W-1:0];
            `RXBS_OFS_MASK: n.mask = bus.wdata[`RXBS_EV_W-1:0];
            default: ;
         endcase
      end

      // Register reads; unmapped offsets and the sync clear bit read zero
      if (bus.rd) begin
         case (bus.addr)
            `RXBS_OFS_CFG_A: rd_v[`RXBS_A_POL_BIT] = q.cfg.polarity_invert;
            `RXBS_OFS_CFG_E: begin
               rd_v[`RXBS_E_MODE_HI:`RXBS_E_MODE_LO] = q.cfg.receive_mode_select;
               rd_v[`RXBS_E_TXCAP_BIT] = q.cfg.tx_capture;
               rd_v[`RXBS_E_PAIR_BIT] = q.cfg.paired_pattern;
               rd_v[`RXBS_E_TLEN_HI:`RXBS_E_TLEN_LO] = q.cfg.training_length_count;
            end
            `RXBS_OFS_RATE: begin
               rd_v[`RXBS_RATE_D1_HI:`RXBS_RATE_D1_LO] = q.cfg.rate_divider_first;
               rd_v[`RXBS_RATE_D2_HI:`RXBS_RATE_D2_LO] = q.cfg.rate_divider_second;
               rd_v[`RXBS_RATE_D3_BIT] = q.cfg.rate_divider_third;
            end
            `RXBS_OFS_STAT: rd_v[`RXBS_EV_W-1:0] = q.stat;
            `RXBS_OFS_MASK: rd_v[`RXBS_EV_W-1:0] = q.mask;
            `RXBS_OFS_STATE: rd_v = {16'h0000, q.tcnt, q.done, q.flag, q.bclk, q.rxd, q.sync, 3'h0};
            default: ;
         endcase
         n.rdata = rd_v;
      end

      // Sample prescaler
      n.pre_cnt = tick ? 10'h000 : q.pre_cnt + 10'h001;

      // Bit phase tracking; a clear outranks a data edge in the same cycle
      if (!recov || q.clr_pend) begin
         n.sync = RXBS_SY_HUNT;
         n.phase = '0;
         n.quiet = '0;
         n.tcnt = '0;
         n.hist = '0;
         n.done = 1'b0;
         n.flag = 1'b0;
      end else if (edge_seen) begin
         if (q.sync == RXBS_SY_HUNT) begin
            ev[`RXBS_EV_LOCK] = 1'b1;
         end
         n.sync = RXBS_SY_LOCK;
         n.phase = '0;
         n.quiet = '0;
         bnd = 1'b1;
      end else if (tick && q.sync == RXBS_SY_LOCK) begin
         if (q.phase >= d3m1) begin
            n.phase = '0;
            bnd = 1'b1;
            // A run longer than the sender may produce means the link is gone
            if (q.quiet == `RXBS_SILENCE_BITS - 6'h01) begin
               ev[`RXBS_EV_LOSS] = 1'b1;
               n.sync = RXBS_SY_HUNT;
               n.quiet = '0;
               n.tcnt = '0;
               n.hist = '0;
               n.done = 1'b0;
               n.flag = 1'b0;
            end else begin
               n.quiet = q.quiet + 6'h01;
            end
         end else begin
            n.phase = q.phase + 5'h01;
            cent = ((q.phase + 5'h01) == half_ph);
         end
      end

      // Training recognition, evaluated on the bit at each centre
      if (cent) begin
         n.flag = 1'b0;
         if (q.cfg.paired_pattern) begin
            match = (q.tcnt < 7'h02) || (q.rxd != q.hist[1]);
         end else begin
            match = (q.tcnt < 7'h01) || (q.rxd != q.hist[0]);
         end
         n.hist = {q.hist[0], q.rxd};
         if (match) begin
            if (q.tcnt != `RXBS_TCNT_MAX) begin
               n.tcnt = q.tcnt + 7'h01;
            end
         end else begin
            if (q.cfg.receive_mode_select == RXBS_M_TRN && !q.done && q.tcnt >= tbmin) begin
               n.flag = 1'b1;
               n.done = 1'b1;
               ev[`RXBS_EV_TRAIN] = 1'b1;
            end
            n.tcnt = 7'h01;
         end
      end
      if (q.cfg.receive_mode_select != RXBS_M_TRN) begin
         n.flag = 1'b0;
      end

      // Per-mode data and clock outputs; inversion applied before the output flop
      unique case (q.cfg.receive_mode_select)
         RXBS_M_RAW: begin
            n.rxd = q.slc_sync[1] ^ q.cfg.polarity_invert;
            n.bclk = 1'b0;
         end
         RXBS_M_DGL: begin
            n.rxd = dg ^ q.cfg.polarity_invert;
            n.bclk = (n.pre_cnt < half_pre);
         end
         RXBS_M_REC, RXBS_M_TRN: begin
            if (bnd) begin
               n.rxd = dg ^ q.cfg.polarity_invert;
            end
            if (n.sync == RXBS_SY_HUNT || bnd) begin
               n.bclk = 1'b0;
            end else if (cent) begin
               n.bclk = 1'b1;
            end
         end
      endcase

      // Transmit capture retimes the host data to the bit clock falling edge
      fall = q.bclk && !n.bclk;
      if (q.cfg.tx_capture) begin
         if (fall) begin
            n.txd = q.txd_sync[1];
         end
      end else begin
         n.txd = q.txd_sync[1];
      end

      // Sticky status: a new event wins over a clear in the same cycle
      n.stat = (q.stat & ~wclr) | ev;
      n.irq = |(n.stat & n.mask);
   end

   // All state, cleared asynchronously except sync, which loads hunt
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.sync <= RXBS_SY_HUNT;
      end else begin
         q <= n;
      end
   end

   assign rdata = q.rdata;
   assign irq = q.irq;
   assign pins.rx_data = q.rxd;
   assign pins.recovered_bit_clock = q.bclk;
   assign pins.training_end_flag = q.flag;
   assign pins.tx_data_out = q.txd;

   raw_quiet_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (q.cfg.receive_mode_select == RXBS_M_RAW) |=> (!q.bclk && !q.flag))
      else $error("raw mode drove clock or flag");
   raw_data_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (q.cfg.receive_mode_select == RXBS_M_RAW) |=> (q.rxd == ($past(q.slc_sync[1]) ^ $past(q.cfg.polarity_invert))))
      else $error("raw data not passed with polarity");
   flag_mode_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (q.cfg.receive_mode_select != RXBS_M_TRN) |=> !q.flag)
      else $error("flag high outside self train");
   hunt_low_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (recov && n.sync == RXBS_SY_HUNT) |=> !q.bclk)
      else $error("bit clock ran before first edge");
   data_on_fall_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ($past(recov) && recov && $stable(q.cfg.polarity_invert) && $changed(q.rxd)) |-> !q.bclk)
      else $error("recovered data changed while bit clock high");
   centre_rise_a: assert property (
      @(posedge core_clk) disable iff (rst)
      ($past(recov) && $rose(q.bclk)) |-> (q.phase == $past(half_ph)))
      else $error("bit clock rose away from bit centre");
   flag_with_clock_a: assert property (
      @(posedge core_clk) disable iff (rst)
      $rose(q.flag) |-> ($rose(q.bclk) && $past(q.tcnt) >= $past(tbmin)))
      else $error("flag rose off clock edge or too early");
   sync_clear_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (recov && bus.wr && bus.addr == `RXBS_OFS_CFG_C && bus.wdata[`RXBS_C_CLR_BIT])
      |=> ##1 (q.sync == RXBS_SY_HUNT && q.tcnt == 7'h00 && !q.flag && !q.bclk))
      else $error("sync clear did not reset recovery");
   set_wins_a: assert property (
      @(posedge core_clk) disable iff (rst)
      (ev[`RXBS_EV_TRAIN] && wclr[`RXBS_EV_TRAIN]) |=> q.stat[`RXBS_EV_TRAIN])
      else $error("status clear beat a new event");

   lock_c: cover property (@(posedge core_clk) disable iff (rst) ev[`RXBS_EV_LOCK]);
   train_end_c: cover property (@(posedge core_clk) disable iff (rst) $rose(q.flag));
   loss_c: cover property (@(posedge core_clk) disable iff (rst) ev[`RXBS_EV_LOSS]);
   deglitch_clk_c: cover property (@(posedge core_clk) disable iff (rst)
      (q.cfg.receive_mode_select == RXBS_M_DGL) && $rose(q.bclk));

endmodule : rxbs_top

// ===== rxbs_host.sv
// Host model: latches received data on bit clock rises and paces its transmit data
`timescale 1ns/1ps
module rxbs_host
   import rxbs_pkg::*;
(
   input wire logic core_clk, // Master clock
   input wire logic rst, // Asynchronous reset, active high
   input wire rxbs_pins_t pins, // Device output pins
   output logic tx_bit, // Transmit data toward the device
   output logic last_bit, // Most recently latched received bit
   output int n_samp // Count of latched bits
);
   logic clk_q;

   // Latch on the rise and move transmit data in the same cycle; a real host lags the rise by a cycle too
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clk_q <= 1'b0;
         tx_bit <= 1'b0;
         last_bit <= 1'b0;
         n_samp <= 0;
      end else begin
         clk_q <= pins.recovered_bit_clock;
         if (pins.recovered_bit_clock && !clk_q) begin
            last_bit <= pins.rx_data;
            tx_bit <= ~tx_bit;
            n_samp <= n_samp + 1;
         end
      end
   end
endmodule : rxbs_host

// ===== rxbs_top_tb.sv
// Testbench for the receive bit synchroniser with host model and cycle monitor
`timescale 1ns/1ps
`include "rxbs_params.svh"
module rxbs_top_tb
   import rxbs_pkg::*;
;
   logic core_clk;
   logic rst;
   rxbs_bus_t bus;
   logic [`RXBS_DW-1:0] rdata;
   logic slicer_in;
   rxbs_pins_t pins;
   logic irq;
   logic tx_bit;
   logic last_bit;
   int n_samp;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int since = 0;
   int run = 0;
   int rises = 0;
   int f_rise = 0;
   int last_rise = 0;
   logic p_rx = 1'b0;
   logic p_clk = 1'b0;
   logic p_flag = 1'b0;
   logic p_tx = 1'b0;
   bit rec_on = 0;
   bit hold_low = 0;
   bit dg_hold = 0;
   bit cap_on = 0;
   bit flag_ok = 0;
   logic [31:0] seed = 32'h57;
   logic [7:0] ofs [3] = '{`RXBS_OFS_STAT, `RXBS_OFS_MASK, 8'h1C};

   rxbs_top dut_u (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .slicer_in(slicer_in),
      .transmit_data_in(tx_bit), .pins(pins), .irq(irq));
   rxbs_host host_u (.core_clk(core_clk), .rst(rst), .pins(pins), .tx_bit(tx_bit), .last_bit(last_bit),
      .n_samp(n_samp));

   // Free running 200 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic fail(input string m);
      bad_count++;
      $display("BAD %0t %s", $time, m);
   endtask : fail

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) fail(m);
   endtask : chk

   // Bus cycles: one strobe cycle each, read data taken in the following cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge core_clk);
      bus.wr <= 1'b0;
      // Let an edge pass so a following write never reassigns the strobe in one step
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
      @(posedge core_clk);
   endtask : rd

   task automatic set_e(input int m, input int cap, input int pair, input int tlen);
      wr(`RXBS_OFS_CFG_E, 32'((m << 14) | (cap << 13) | (pair << 12) | (tlen << 7)));
   endtask : set_e

   // One bit of sixteen cycles at the slicer pin
   task automatic send(input logic b);
      slicer_in <= b;
      repeat (16) @(posedge core_clk);
   endtask : send

   // Cycle ceiling; a clean run needs about 2200 cycles
   always @(negedge core_clk) begin
      if (cyc >= 20000) begin
         fail("run did not finish in time");
         wrap_up();
      end
   end

   // Cycle monitor at the falling edge, where every output has settled
   always @(negedge core_clk) begin
      cyc++;
      since = (pins.rx_data !== p_rx) ? 0 : since + 1;
      if (pins.recovered_bit_clock && !p_clk) begin
         rises++;
         if (rec_on && since < 16) chk(since, 8, "clock rise off bit centre");
         if (rec_on && last_rise > 0) chk(cyc - last_rise, 16, "bit period");
         last_rise = cyc;
      end
      if (hold_low && pins.recovered_bit_clock) fail("clock ran before a data edge");
      if (dg_hold) chk(pins.rx_data, 1'b1, "glitch passed filter");
      if (cap_on && pins.tx_data_out !== p_tx && !(p_clk && !pins.recovered_bit_clock)) fail("tx off fall");
      if (!flag_ok && pins.training_end_flag) fail("flag outside self train");
      if (pins.training_end_flag && !p_flag) begin
         f_rise++;
         chk(pins.recovered_bit_clock && !p_clk, 1'b1, "flag not with clock rise");
      end
      run = pins.training_end_flag ? run + 1 : run;
      if (!pins.training_end_flag && p_flag) begin
         chk(run, 16, "flag length");
         run = 0;
      end
      p_rx = pins.rx_data;
      p_clk = pins.recovered_bit_clock;
      p_flag = pins.training_end_flag;
      p_tx = pins.tx_data_out;
   end

   // Main sequence
   initial begin
      logic [31:0] d;
      int tbmin;
      int nt;
      int n0;
      logic q [$];
      rst = 1'b1;
      bus = '0;
      slicer_in = 1'b0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(`RXBS_OFS_STATE, d);
      chk(d & 32'hFF80, 32'h0, "count, done or flag not clear");
      for (int i = 0; i < 3; i++) begin
         rd(ofs[i], d);
         chk(d, 32'h0, "register not zero after reset");
      end
      $display("test reset done");
      // Raw path with both polarities, random pin levels
      for (int pol = 0; pol < 2; pol++) begin
         wr(`RXBS_OFS_CFG_A, 32'(pol << 4));
         for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            slicer_in <= seed[0];
            repeat (4) @(posedge core_clk);
            #1;
            chk({pins.rx_data, pins.recovered_bit_clock}, {seed[0] ^ pol[0], 1'b0}, "raw path");
            @(posedge core_clk);
         end
      end
      wr(`RXBS_OFS_CFG_A, 32'h0);
      $display("test raw done");
      // Deglitch: ten cycles per tick, a two-sample glitch must not pass
      wr(`RXBS_OFS_RATE, 32'h5);
      set_e(1, 0, 0, 0);
      slicer_in <= 1'b1;
      repeat (150) @(posedge core_clk);
      rises = 0;
      repeat (200) @(posedge core_clk);
      chk(rises, 20, "filter clock rate");
      chk(pins.rx_data, 1'b1, "filter settles high");
      dg_hold = 1;
      slicer_in <= 1'b0;
      repeat (15) @(posedge core_clk);
      slicer_in <= 1'b1;
      repeat (100) @(posedge core_clk);
      dg_hold = 0;
      slicer_in <= 1'b0;
      repeat (100) @(posedge core_clk);
      chk(pins.rx_data, 1'b0, "filter settles low");
      $display("test deglitch done");
      // Clock recovery with transmit capture, sixteen one-cycle ticks per bit
      wr(`RXBS_OFS_RATE, 32'h20);
      set_e(2, 1, 0, 0);
      wr(`RXBS_OFS_CFG_C, 32'h20);
      repeat (3) @(posedge core_clk);
      hold_low = 1;
      rd(`RXBS_OFS_STATE, d);
      chk(d[4:3], 2'b01, "not hunting after clear");
      repeat (50) @(posedge core_clk);
      hold_low = 0;
      rec_on = 1;
      last_rise = 0;
      cap_on = 1;
      n0 = n_samp;
      for (int i = 0; i < 24; i++) send(~i[0]);
      rec_on = 0;
      cap_on = 0;
      send(1'b0);
      chk(last_bit, 1'b0, "host latched wrong bit");
      chk(n_samp - n0, 24, "host sample count");
      chk(pins.tx_data_out, tx_bit, "tx capture lost data");
      $display("test recovery done");
      // Self train, single and paired patterns, runs just short of and past the minimum
      for (int p = 0; p < 2; p++) begin
         for (int ok = 0; ok < 2; ok++) begin
            tbmin = 4 * 2 + p + 2;
            nt = ok ? tbmin + 3 : tbmin - 3;
            set_e(3, 0, p, 2);
            wr(`RXBS_OFS_CFG_C, 32'h20);
            repeat (3) @(posedge core_clk);
            flag_ok = 1;
            f_rise = 0;
            q = {};
            for (int i = 0; i < nt; i++) q.push_back(((p ? i / 2 : i) % 2 == 0) ? ~slicer_in : slicer_in);
            q.push_back(q[q.size() - 1 - p]);
            for (int i = 0; i < 3; i++) q.push_back(~q[q.size() - 1]);
            foreach (q[i]) send(q[i]);
            repeat (20) @(posedge core_clk);
            chk(f_rise, ok, "training end count");
         end
      end
      flag_ok = 0;
      $display("test self train done");
      // Interrupt: event sticky, masked, then cleared by writing one
      rd(`RXBS_OFS_STAT, d);
      chk(d[0], 1'b1, "training event not recorded");
      #1;
      chk(irq, 1'b0, "irq while masked");
      @(posedge core_clk);
      wr(`RXBS_OFS_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b1, "irq not raised");
      @(posedge core_clk);
      wr(`RXBS_OFS_STAT, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b0, "irq not cleared");
      $display("test interrupt done");
      wrap_up();
   end
endmodule : rxbs_top_tb
